// >>> tape_ctrl_assertions.sv
// Checker for motion, read strobe, write clock and brake behaviour
`timescale 1ns/100ps
module tape_ctrl_chk (
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic RST_I,
  // Watched inputs
  input wire logic ONLINE_I,
  input wire logic SELECTED_I,
  input wire logic POWER_OK_I,
  input wire logic HALT_OVERRIDE_I,
  input wire logic COMMAND_LOAD_STROBE_I,
  input wire logic AHEAD_REQUEST_I,
  input wire logic BACKWARD_REQUEST_I,
  input wire logic SPOOL_BACK_REQUEST_I,
  input wire logic PHASE_MODE_SELECT_I,
  input wire logic SPOOL_DRIVE_ENABLE_I,
  // Watched outputs
  input wire logic CAPSTAN_AHEAD_CMD_O,
  input wire logic BACKWARD_OR_SPOOLBACK_CMD_O,
  input wire logic WRITE_TIMING_CLOCK_O,
  input wire logic NRZI_READ_STROBE_O,
  input wire logic UPPER_BRAKE_O,
  input wire logic LOWER_BRAKE_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  // Load edge with ahead request, then the lines held through sync
  sequence s_ahead_load;
    $rose(COMMAND_LOAD_STROBE_I) && AHEAD_REQUEST_I;
  endsequence
  sequence s_ahead_held;
    (ONLINE_I && SELECTED_I && !HALT_OVERRIDE_I && AHEAD_REQUEST_I
      && !BACKWARD_REQUEST_I && !SPOOL_BACK_REQUEST_I)[*4];
  endsequence
  AST_LOAD_AHEAD: assert property (
    s_ahead_load ##0 s_ahead_held |=> CAPSTAN_AHEAD_CMD_O)
    else $error("ahead load not obeyed");
  AST_HALT_STOP: assert property (
    (HALT_OVERRIDE_I && ONLINE_I && SELECTED_I)[*5]
    |=> !CAPSTAN_AHEAD_CMD_O && !BACKWARD_OR_SPOOLBACK_CMD_O)
    else $error("motion under halt");
  AST_UNSELECTED_HOLD: assert property (
    (ONLINE_I && !SELECTED_I)[*5]
    |=> $stable(CAPSTAN_AHEAD_CMD_O) && $stable(BACKWARD_OR_SPOOLBACK_CMD_O))
    else $error("motion changed while unselected");
  AST_ONE_DIRECTION: assert property (
    !(CAPSTAN_AHEAD_CMD_O && BACKWARD_OR_SPOOLBACK_CMD_O))
    else $error("both directions");
  AST_PE_NO_STROBE: assert property (
    PHASE_MODE_SELECT_I[*8] |=> !NRZI_READ_STROBE_O)
    else $error("read strobe in PE");
  AST_STROBE_PULSE: assert property (
    $rose(NRZI_READ_STROBE_O) |=> !NRZI_READ_STROBE_O)
    else $error("read strobe too long");
  AST_WCLK_GATED: assert property (
    (!POWER_OK_I || !ONLINE_I)[*5] |=> !WRITE_TIMING_CLOCK_O)
    else $error("write clock while not ready");
  AST_BRAKES_ON: assert property (
    !SPOOL_DRIVE_ENABLE_I[*5] |=> UPPER_BRAKE_O && LOWER_BRAKE_O)
    else $error("brakes off while disabled");
endmodule
bind tape_transport_motion_write_ctrl tape_ctrl_chk u_tape_ctrl_chk (.*);

// >>> tape_ctrl_model.sv
// Controller model: record and parity strobes timed from the write clock
`timescale 1ns/100ps
module tape_ctrl_model (
  // Clock
  input wire logic clk_i,
  // Write clock and bench requests
  input wire logic wclk_i,
  input wire logic go_i,
  input wire logic lrc_i,
  // Strobes to the transport
  output logic rec_o,
  output logic lrc_o
);
  logic wclk_q;
  initial begin
    wclk_q = 1'b0;
    rec_o = 1'b0;
    lrc_o = 1'b0;
  end
  // Record starts at a write clock rise; parity strobe in the low half before
  always @(posedge clk_i) begin
    wclk_q <= wclk_i;
    rec_o <= go_i && wclk_i && (!wclk_q || rec_o);
    lrc_o <= go_i && lrc_i && !wclk_i;
  end
endmodule

// >>> tape_transport_motion_write_ctrl.sv
// Tape transport motion command, write buffer, read mux and reel control
`timescale 1ns/100ps
`include "tape_xport_map.svh"
module tape_transport_motion_write_ctrl #(
  parameter int unsigned RAMP_DELAY_CYC = `RAMP_DELAY_MS * `MCLK_KHZ,
  parameter int unsigned ACCEL_CYC = `ACCEL_MS * `MCLK_KHZ
) (
  // Clock, reset, enable
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  // Register port
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  // Transport state pins
  input wire logic ONLINE_I,
  input wire logic SELECTED_I,
  input wire logic LOADED_I,
  input wire logic POWER_OK_I,
  // Controller motion lines
  input wire logic HALT_OVERRIDE_I,
  input wire logic COMMAND_LOAD_STROBE_I,
  input wire logic AHEAD_REQUEST_I,
  input wire logic BACKWARD_REQUEST_I,
  input wire logic SPOOL_BACK_REQUEST_I,
  // Controller write and read lines
  input wire logic TAPE_STORE_COMMAND_I,
  input wire logic PHASE_MODE_SELECT_I,
  input wire logic WRITE_STROBE_PULSE_I,
  input wire logic PARITY_CHAR_STROBE_I,
  input wire logic [8:0] OUTGOING_TAPE_BYTE_I,
  output logic WRITE_TIMING_CLOCK_O,
  output logic [8:0] READBACK_O,
  output logic NRZI_READ_STROBE_O,
  // Off-line maintenance sources
  input wire logic REWIND_SWITCH_I,
  input wire logic DIRECTION_SWITCH_I,
  input wire logic START_STOP_SWITCH_I,
  input wire logic TEST_GEN_PULSE_A_I,
  input wire logic TEST_GEN_PULSE_B_I,
  input wire logic TEST_WRITE_TRIGGER_I,
  input wire logic [8:0] TEST_DATA_I,
  // Read amplifier
  input wire logic [8:0] TAPE_READ_DATA_I,
  input wire logic TAPE_READ_EDGE_I,
  // Vacuum column switches and reel enable
  input wire logic LEFT_COL_SHORT_I,
  input wire logic LEFT_COL_LONG_I,
  input wire logic RIGHT_COL_SHORT_I,
  input wire logic RIGHT_COL_LONG_I,
  input wire logic SPOOL_DRIVE_ENABLE_I,
  // Capstan commands
  output logic CAPSTAN_AHEAD_CMD_O,
  output logic BACKWARD_OR_SPOOLBACK_CMD_O,
  output logic HIGH_SPEED_RAMP_CMD_O,
  // Reel brakes and motors
  output logic UPPER_BRAKE_O,
  output logic UPPER_MOTOR_FILL_O,
  output logic UPPER_MOTOR_TAKE_O,
  output logic LOWER_BRAKE_O,
  output logic LOWER_MOTOR_FILL_O,
  output logic LOWER_MOTOR_TAKE_O,
  // Write head drive
  output logic WRITE_ENABLE_O,
  output logic [8:0] WRITE_HEAD_O
);

  tape_xport_pkg::state_s q;
  tape_xport_pkg::state_s d;
  logic [`SY_W-1:0] sy;
  logic [`SY_CTL_W-1:0] rise;
  logic on_sel;
  logic ss_toggle;
  logic tick;
  logic rec;
  logic [8:0] wdata;
  logic [15:0] div;
  logic moving;
  logic fast;
  logic [31:0] status;

  // Reel loop control: returns brake, fill, take
  function automatic logic [2:0] reel_ctl(input logic short_loop, input logic long_loop,
                                          input logic pay_out, input logic hi_speed,
                                          input logic run, input logic enable);
    logic [2:0] r;
    r = 3'h0;
    if (!enable) begin
      r = 3'h4;
    end else if (short_loop) begin
      r = 3'h2;
    end else if (long_loop) begin
      r = 3'h1;
    end else if (hi_speed) begin
      r = pay_out ? 3'h2 : 3'h1;
    end else if (!run) begin
      r = 3'h4;
    end
    return r;
  endfunction

  // Off-line jog direction from the direction switch
  function automatic tape_xport_pkg::motion_e jog_dir(input logic reverse);
    return reverse ? tape_xport_pkg::MOT_BACK : tape_xport_pkg::MOT_AHEAD;
  endfunction

  // Saturating run-time counter
  function automatic logic [31:0] sat_inc(input logic [31:0] v, input logic [31:0] lim);
    logic [31:0] r;
    r = v;
    if (v < lim) begin
      r = v + 32'h0000_0001;
    end
    return r;
  endfunction

  // Motion request lines to a command; no line means stop
  function automatic tape_xport_pkg::motion_e req_decode(input logic ahead, input logic back,
                                                          input logic spool);
    tape_xport_pkg::motion_e m;
    m = tape_xport_pkg::MOT_STOP;
    if (ahead) begin
      m = tape_xport_pkg::MOT_AHEAD;
    end else if (back) begin
      m = tape_xport_pkg::MOT_BACK;
    end else if (spool) begin
      m = tape_xport_pkg::MOT_SPOOL;
    end
    return m;
  endfunction

  // Next-state logic
  always_comb begin
    d = q;
    d.rdata = 32'h0000_0000;
    d.rstrobe = 1'b0;
    // Two-stage synchronisers for every pin except the register port, clock enable and reset
    // Only the second stage is ever read by logic
    d.sync1 = {TAPE_READ_DATA_I, TEST_DATA_I, OUTGOING_TAPE_BYTE_I, TAPE_READ_EDGE_I,
               SPOOL_DRIVE_ENABLE_I, RIGHT_COL_LONG_I, RIGHT_COL_SHORT_I, LEFT_COL_LONG_I,
               LEFT_COL_SHORT_I, TEST_WRITE_TRIGGER_I, TEST_GEN_PULSE_B_I, TEST_GEN_PULSE_A_I,
               START_STOP_SWITCH_I, DIRECTION_SWITCH_I, REWIND_SWITCH_I, POWER_OK_I,
               LOADED_I, SELECTED_I, ONLINE_I, PARITY_CHAR_STROBE_I, WRITE_STROBE_PULSE_I,
               PHASE_MODE_SELECT_I, TAPE_STORE_COMMAND_I, SPOOL_BACK_REQUEST_I,
               BACKWARD_REQUEST_I, AHEAD_REQUEST_I, COMMAND_LOAD_STROBE_I, HALT_OVERRIDE_I};
    d.sync2 = q.sync1;
    sy = q.sync2;
    d.prev = sy[`SY_CTL_W-1:0];
    rise = sy[`SY_CTL_W-1:0] & ~q.prev;
    on_sel = sy[`SY_ONLINE] & sy[`SY_SELECT];
    // A start/stop switch change or a test pulse rise flips the run state
    ss_toggle = (sy[`SY_SSSW] ^ q.prev[`SY_SSSW]) | rise[`SY_TGA] | rise[`SY_TGB];

    // Motion command capture
    if (on_sel) begin
      if (rise[`SY_LOAD] && !sy[`SY_HALT]) begin
        d.motion = req_decode(sy[`SY_AHEAD], sy[`SY_BACK], sy[`SY_SPOOL]);
        d.write_en = sy[`SY_STORE];
        d.lrc_armed = 1'b0;
      end
      d.off_run = 1'b0;
    end else if (!sy[`SY_ONLINE]) begin
      if (rise[`SY_REWSW]) begin
        d.motion = tape_xport_pkg::MOT_SPOOL;
        d.off_run = 1'b0;
      end else if (ss_toggle) begin
        d.off_run = ~q.off_run;
        d.motion = tape_xport_pkg::MOT_STOP;
        if (!q.off_run) begin
          d.motion = jog_dir(sy[`SY_DIRSW]);
        end
      end else if (q.off_run) begin
        d.motion = jog_dir(sy[`SY_DIRSW]);
      end
      d.write_en = sy[`SY_TWT];
      d.lrc_armed = 1'b0;
    end
    // Held command otherwise; halt wins over everything
    // Halt acts only for the selected on-line drive
    if (on_sel && sy[`SY_HALT]) begin
      d.motion = tape_xport_pkg::MOT_STOP;
      d.off_run = 1'b0;
    end

    // Rewind ramp delay and acceleration timers
    d.ramp_cnt = 32'h0000_0000;
    if (q.motion == tape_xport_pkg::MOT_SPOOL && d.motion == tape_xport_pkg::MOT_SPOOL) begin
      d.ramp_cnt = sat_inc(q.ramp_cnt, RAMP_DELAY_CYC);
    end
    d.accel_cnt = 32'h0000_0000;
    if (q.motion != tape_xport_pkg::MOT_STOP && d.motion != tape_xport_pkg::MOT_STOP) begin
      d.accel_cnt = sat_inc(q.accel_cnt, ACCEL_CYC);
    end
    d.at_speed = (d.accel_cnt >= ACCEL_CYC);

    // Capstan command lines
    d.cap_ahead = (d.motion == tape_xport_pkg::MOT_AHEAD);
    d.cap_back = (d.motion == tape_xport_pkg::MOT_BACK) ||
                 (d.motion == tape_xport_pkg::MOT_SPOOL);
    d.hs_ramp = (d.ramp_cnt >= RAMP_DELAY_CYC);

    // Reel motors and brakes per column
    // Column switches override; idle reels brake
    moving = (q.motion != tape_xport_pkg::MOT_STOP);
    fast = q.hs_ramp;
    d.reel[5:3] = reel_ctl(sy[`SY_LCOL_SHORT], sy[`SY_LCOL_LONG], q.cap_ahead, fast, moving,
                           sy[`SY_REEL_EN]);
    d.reel[2:0] = reel_ctl(sy[`SY_RCOL_SHORT], sy[`SY_RCOL_LONG], q.cap_back, fast, moving,
                           sy[`SY_REEL_EN]);

    // Write timing clock divider, rate by phase mode
    // Held low with the counter cleared to zero whenever the drive is not ready
    div = sy[`SY_PHASE] ? q.pe_div : q.nrzi_div;
    tick = 1'b0;
    if (sy[`SY_POWER] && sy[`SY_LOADED] && q.at_speed) begin
      if (q.wclk_cnt == 16'h0000) begin
        d.wclk_cnt = div;
        d.wclk = ~q.wclk;
        tick = ~q.wclk;
      end else begin
        d.wclk_cnt = q.wclk_cnt - 16'h0001;
      end
    end else begin
      d.wclk_cnt = 16'h0000;
      d.wclk = 1'b0;
    end
    d.wclk_o = d.wclk & sy[`SY_ONLINE];

    // Record pulses: controller strobe or test generator
    // Off-line the internal write clock paces the test writer
    if (sy[`SY_ONLINE]) begin
      rec = rise[`SY_WSTRB] & q.write_en;
      wdata = sy[`SY_WD +: 9];
    end else begin
      rec = tick & q.write_en & sy[`SY_TWT];
      wdata = sy[`SY_TD +: 9];
    end
    if (rec) begin
      if (sy[`SY_PHASE]) begin
        d.head = wdata;
      end else if (q.lrc_armed) begin
        d.head = 9'h000;
        d.lrc_armed = 1'b0;
      end else begin
        d.head = q.head ^ wdata;
      end
    end

    // Parity character strobe, NRZI on-line only
    // After the record pulse, so a new strobe wins over the clear
    if (rise[`SY_LRC] && !sy[`SY_PHASE] && sy[`SY_ONLINE] && q.write_en) begin
      d.lrc_armed = 1'b1;
    end

    // Read path: skew window and strobe in NRZI
    // The window hides skew between tracks before sampling
    if (sy[`SY_PHASE]) begin
      d.skew_busy = 1'b0;
      d.rd_latch = sy[`SY_RD +: 9];
    end else if (q.skew_busy) begin
      if (q.skew_cnt == 8'h00) begin
        d.skew_busy = 1'b0;
        d.rstrobe = 1'b1;
        d.rd_latch = sy[`SY_RD +: 9];
      end else begin
        d.skew_cnt = q.skew_cnt - 8'h01;
      end
    end else if (rise[`SY_RDEDGE]) begin
      d.skew_busy = 1'b1;
      d.skew_cnt = q.skew_dly;
    end
    d.readback = q.preset_sel ? q.preset : d.rd_latch;

    // Register writes
    // Unmapped addresses leave every register alone
    if (WR_I) begin
      case (ADDR_I)
        `REG_CTRL: d.preset_sel = WDATA_I[`CTRL_PRESET_SEL];
        `REG_PRESET: d.preset = WDATA_I[8:0];
        `REG_NRZI_DIV: d.nrzi_div = WDATA_I[15:0];
        `REG_PE_DIV: d.pe_div = WDATA_I[15:0];
        `REG_SKEW: d.skew_dly = WDATA_I[7:0];
        default: d.preset_sel = q.preset_sel;
      endcase
    end
    // Status word, one field at a time
    status = 32'h0000_0000;
    status[`STS_MOTION +: 2] = q.motion;
    status[`STS_OFF_RUN] = q.off_run;
    status[`STS_HS_RAMP] = q.hs_ramp;
    status[`STS_AT_SPEED] = q.at_speed;
    status[`STS_WRITE_EN] = q.write_en;
    status[`STS_LRC_ARMED] = q.lrc_armed;
    status[`STS_PHASE] = sy[`SY_PHASE];
    status[`STS_ONLINE] = sy[`SY_ONLINE];
    status[`STS_SELECTED] = sy[`SY_SELECT];
    // Register reads, data in the next cycle
    if (RD_I) begin
      case (ADDR_I)
        `REG_CTRL: d.rdata = {31'h0000_0000, q.preset_sel};
        `REG_PRESET: d.rdata = {23'h00_0000, q.preset};
        `REG_NRZI_DIV: d.rdata = {16'h0000, q.nrzi_div};
        `REG_PE_DIV: d.rdata = {16'h0000, q.pe_div};
        `REG_SKEW: d.rdata = {24'h00_0000, q.skew_dly};
        `REG_STATUS: d.rdata = status;
        `REG_WBUF: d.rdata = {23'h00_0000, q.head};
        default: d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register
  // Everything holds its value while the clock enable is low
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      q <= '0;
      q.motion <= tape_xport_pkg::MOT_STOP;
      q.preset <= `RST_PRESET;
      q.nrzi_div <= `RST_NRZI_DIV;
      q.pe_div <= `RST_PE_DIV;
      q.skew_dly <= `RST_SKEW;
    end else if (CE_I) begin
      q <= d;
    end
  end

  // Outputs straight from state flops
  assign RDATA_O = q.rdata;
  assign WRITE_TIMING_CLOCK_O = q.wclk_o;
  assign READBACK_O = q.readback;
  assign NRZI_READ_STROBE_O = q.rstrobe;
  // Capstan lines
  assign CAPSTAN_AHEAD_CMD_O = q.cap_ahead;
  assign BACKWARD_OR_SPOOLBACK_CMD_O = q.cap_back;
  assign HIGH_SPEED_RAMP_CMD_O = q.hs_ramp;
  // Reel brakes and motors
  assign UPPER_BRAKE_O = q.reel[5];
  assign UPPER_MOTOR_FILL_O = q.reel[4];
  assign UPPER_MOTOR_TAKE_O = q.reel[3];
  assign LOWER_BRAKE_O = q.reel[2];
  assign LOWER_MOTOR_FILL_O = q.reel[1];
  assign LOWER_MOTOR_TAKE_O = q.reel[0];
  // Write path
  assign WRITE_ENABLE_O = q.write_en;
  assign WRITE_HEAD_O = q.head;

endmodule

// >>> tape_transport_motion_write_ctrl_tb.sv
// Self-checking bench for the tape transport motion and write control block
`timescale 1ns/100ps
module tape_transport_motion_write_ctrl_tb;
  logic MCLK_I = 0, RST_I = 1, CE_I = 1, WR_I = 0, RD_I = 0;
  logic [7:0] ADDR_I = 8'h00;
  logic [31:0] WDATA_I = 32'h0000_0000, RDATA_O;
  logic ONLINE_I = 1, SELECTED_I = 1, LOADED_I = 0, POWER_OK_I = 0;
  logic HALT_OVERRIDE_I = 0, COMMAND_LOAD_STROBE_I = 0, AHEAD_REQUEST_I = 0;
  logic BACKWARD_REQUEST_I = 0, SPOOL_BACK_REQUEST_I = 0, TAPE_STORE_COMMAND_I = 0;
  logic PHASE_MODE_SELECT_I = 1, WRITE_STROBE_PULSE_I, PARITY_CHAR_STROBE_I;
  logic [8:0] OUTGOING_TAPE_BYTE_I = 9'h000, TEST_DATA_I = 9'h000;
  logic [8:0] TAPE_READ_DATA_I = 9'h000, READBACK_O, WRITE_HEAD_O;
  logic WRITE_TIMING_CLOCK_O, NRZI_READ_STROBE_O, WRITE_ENABLE_O;
  logic REWIND_SWITCH_I = 0, DIRECTION_SWITCH_I = 0, START_STOP_SWITCH_I = 0;
  logic TEST_GEN_PULSE_A_I = 0, TEST_GEN_PULSE_B_I = 0, TEST_WRITE_TRIGGER_I = 0;
  logic TAPE_READ_EDGE_I = 0, LEFT_COL_SHORT_I = 0, LEFT_COL_LONG_I = 0;
  logic RIGHT_COL_SHORT_I = 0, RIGHT_COL_LONG_I = 0, SPOOL_DRIVE_ENABLE_I = 0;
  logic CAPSTAN_AHEAD_CMD_O, BACKWARD_OR_SPOOLBACK_CMD_O, HIGH_SPEED_RAMP_CMD_O;
  logic UPPER_BRAKE_O, UPPER_MOTOR_FILL_O, UPPER_MOTOR_TAKE_O;
  logic LOWER_BRAKE_O, LOWER_MOTOR_FILL_O, LOWER_MOTOR_TAKE_O;
  logic go = 0, par = 0;
  int bad_count = 0, total_checks = 0;
  // Short ramp and accel counts keep the run brief
  tape_transport_motion_write_ctrl #(.RAMP_DELAY_CYC(20), .ACCEL_CYC(10))
    u_tape_transport_motion_write_ctrl (.*);
  tape_ctrl_model u_tape_ctrl_model (.clk_i(MCLK_I), .wclk_i(WRITE_TIMING_CLOCK_O),
    .go_i(go), .lrc_i(par), .rec_o(WRITE_STROBE_PULSE_I), .lrc_o(PARITY_CHAR_STROBE_I));
  always #2 MCLK_I = ~MCLK_I;
  task automatic wrap_up;
    if (bad_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge MCLK_I);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK_I);
    WR_I <= 1;
    ADDR_I <= a;
    WDATA_I <= d;
    @(posedge MCLK_I);
    WR_I <= 0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    @(posedge MCLK_I);
    RD_I <= 1;
    ADDR_I <= a;
    @(posedge MCLK_I);
    RD_I <= 0;
    @(negedge MCLK_I);
    chk(RDATA_O, e);
  endtask
  // One request line, then a two-cycle load pulse
  task automatic ld(input logic [2:0] req, input logic st);
    @(posedge MCLK_I);
    {SPOOL_BACK_REQUEST_I, BACKWARD_REQUEST_I, AHEAD_REQUEST_I} <= req;
    TAPE_STORE_COMMAND_I <= st;
    cyc(2);
    COMMAND_LOAD_STROBE_I <= 1;
    cyc(2);
    COMMAND_LOAD_STROBE_I <= 0;
    cyc(6);
  endtask
  task automatic cap(input logic [2:0] e);
    @(negedge MCLK_I);
    chk({HIGH_SPEED_RAMP_CMD_O, BACKWARD_OR_SPOOLBACK_CMD_O, CAPSTAN_AHEAD_CMD_O}, e);
    @(posedge MCLK_I);
  endtask
  // Write clock seen toggling (e=1) or held still (e=0) over 40 cycles
  task automatic wck(input logic e);
    int hi;
    hi = 0;
    repeat (40) begin
      @(posedge MCLK_I);
      hi += WRITE_TIMING_CLOCK_O;
    end
    chk(hi > 0 && hi < 40, e);
  endtask
  // One character through the controller model
  task automatic wr_char(input logic [8:0] d, input logic p);
    int n;
    @(posedge MCLK_I);
    OUTGOING_TAPE_BYTE_I <= d;
    par <= p;
    go <= 1;
    for (n = 0; n < 200 && !WRITE_STROBE_PULSE_I; n++) @(posedge MCLK_I);
    go <= 0;
    par <= 0;
    cyc(10);
    chk(n < 200, 1);
  endtask
  task automatic t_regs;
    rreg(8'h08, 32'h0000_0010);
    rreg(8'h1C, 32'h0000_0000);
    wreg(8'h04, 32'h0000_0155);
    wreg(8'h00, 32'h0000_0001);
    cyc(3);
    chk(READBACK_O, 9'h155);
    wreg(8'h00, 32'h0000_0000);
  endtask
  task automatic t_motion;
    ld(3'b001, 0);
    cap(3'b001);
    cyc(30);
    cap(3'b001);
    ld(3'b010, 0);
    cap(3'b010);
    ld(3'b100, 0);
    cap(3'b010);
    cyc(25);
    cap(3'b110);
    HALT_OVERRIDE_I <= 1;
    cyc(8);
    cap(3'b000);
    ld(3'b001, 0);
    cap(3'b000);
    HALT_OVERRIDE_I <= 0;
    SELECTED_I <= 0;
    ld(3'b001, 0);
    cap(3'b000);
    SELECTED_I <= 1;
  endtask
  task automatic t_write;
    ld(3'b001, 1);
    SPOOL_DRIVE_ENABLE_I <= 1;
    LEFT_COL_SHORT_I <= 1;
    RIGHT_COL_LONG_I <= 1;
    cyc(20);
    chk({UPPER_MOTOR_FILL_O, LOWER_MOTOR_TAKE_O, WRITE_ENABLE_O}, 3'b111);
    wck(1);
    wr_char(9'h1A5, 1);
    chk(WRITE_HEAD_O, 9'h1A5);
    PHASE_MODE_SELECT_I <= 0;
    cyc(8);
    wr_char(9'h03C, 0);
    chk(WRITE_HEAD_O, 9'h199);
    wr_char(9'h0FF, 1);
    chk(WRITE_HEAD_O, 9'h000);
    HALT_OVERRIDE_I <= 1;
    cyc(8);
    HALT_OVERRIDE_I <= 0;
    LEFT_COL_SHORT_I <= 0;
    RIGHT_COL_LONG_I <= 0;
    cyc(8);
    chk({UPPER_BRAKE_O, UPPER_MOTOR_FILL_O, UPPER_MOTOR_TAKE_O, LOWER_BRAKE_O,
         LOWER_MOTOR_FILL_O, LOWER_MOTOR_TAKE_O}, 6'b100100);
  endtask
  task automatic t_read;
    int n;
    logic hit;
    hit = 0;
    @(posedge MCLK_I);
    TAPE_READ_DATA_I <= 9'h0C3;
    TAPE_READ_EDGE_I <= 1;
    for (n = 0; n < 60 && !NRZI_READ_STROBE_O; n++) begin
      @(posedge MCLK_I);
      if (n == 9) TAPE_READ_EDGE_I <= 0;
    end
    chk(n >= 33 && n <= 44, 1);
    cyc(2);
    chk(READBACK_O, 9'h0C3);
    PHASE_MODE_SELECT_I <= 1;
    TAPE_READ_DATA_I <= 9'h13A;
    cyc(10);
    TAPE_READ_EDGE_I <= 1;
    repeat (60) begin
      @(posedge MCLK_I);
      hit = hit | NRZI_READ_STROBE_O;
    end
    chk(hit, 0);
    chk(READBACK_O, 9'h13A);
    TAPE_READ_EDGE_I <= 0;
  endtask
  task automatic t_offline;
    ONLINE_I <= 0;
    cyc(6);
    START_STOP_SWITCH_I <= 1;
    cyc(8);
    cap(3'b001);
    START_STOP_SWITCH_I <= 0;
    cyc(8);
    cap(3'b000);
    DIRECTION_SWITCH_I <= 1;
    TEST_GEN_PULSE_A_I <= 1;
    cyc(8);
    cap(3'b010);
    TEST_GEN_PULSE_B_I <= 1;
    cyc(8);
    cap(3'b000);
    DIRECTION_SWITCH_I <= 0;
    START_STOP_SWITCH_I <= 1;
    TEST_DATA_I <= 9'h0F0;
    TEST_WRITE_TRIGGER_I <= 1;
    par <= 1;
    cyc(80);
    chk({WRITE_ENABLE_O, WRITE_HEAD_O}, {1'b1, 9'h0F0});
    wck(0);
    TEST_WRITE_TRIGGER_I <= 0;
    PHASE_MODE_SELECT_I <= 0;
    go <= 1;
    cyc(8);
    rreg(8'h14, 32'h0000_0215);
    go <= 0;
    par <= 0;
    START_STOP_SWITCH_I <= 0;
    cyc(8);
    REWIND_SWITCH_I <= 1;
    cyc(30);
    cap(3'b110);
    ONLINE_I <= 1;
    HALT_OVERRIDE_I <= 1;
    cyc(8);
    HALT_OVERRIDE_I <= 0;
    START_STOP_SWITCH_I <= 1;
    cyc(8);
    cap(3'b000);
  endtask
  initial begin
    #100000;
    bad_count++;
    wrap_up;
  end
  initial begin
    cyc(6);
    RST_I <= 0;
    cyc(10);
    POWER_OK_I <= 1;
    LOADED_I <= 1;
    t_regs;
    t_motion;
    t_write;
    t_read;
    t_offline;
    wrap_up;
  end
endmodule

// >>> tape_xport_map.svh
// Register offsets, field positions, reset values and timing figures
`ifndef TAPE_XPORT_MAP_SVH
`define TAPE_XPORT_MAP_SVH
// Register offsets
`define REG_CTRL 8'h00
`define REG_PRESET 8'h04
`define REG_NRZI_DIV 8'h08
`define REG_PE_DIV 8'h0C
`define REG_SKEW 8'h10
`define REG_STATUS 8'h14
`define REG_WBUF 8'h18
// Control field: readback source select
`define CTRL_PRESET_SEL 0
// Status word field positions
`define STS_MOTION 0
`define STS_OFF_RUN 2
`define STS_HS_RAMP 3
`define STS_AT_SPEED 4
`define STS_WRITE_EN 5
`define STS_LRC_ARMED 6
`define STS_PHASE 7
`define STS_ONLINE 8
`define STS_SELECTED 9
// Reset values
`define RST_PRESET 9'h000
`define RST_NRZI_DIV 16'h0010
`define RST_PE_DIV 16'h0008
`define RST_SKEW 8'h20
// Timing: clock rate and delays
`define MCLK_KHZ 250000
`define RAMP_DELAY_MS 200
`define ACCEL_MS 8
// Synchroniser vector positions
`define SY_HALT 0
`define SY_LOAD 1
`define SY_AHEAD 2
`define SY_BACK 3
`define SY_SPOOL 4
`define SY_STORE 5
`define SY_PHASE 6
`define SY_WSTRB 7
`define SY_LRC 8
`define SY_ONLINE 9
`define SY_SELECT 10
`define SY_LOADED 11
`define SY_POWER 12
`define SY_REWSW 13
`define SY_DIRSW 14
`define SY_SSSW 15
`define SY_TGA 16
`define SY_TGB 17
`define SY_TWT 18
`define SY_LCOL_SHORT 19
`define SY_LCOL_LONG 20
`define SY_RCOL_SHORT 21
`define SY_RCOL_LONG 22
`define SY_REEL_EN 23
`define SY_RDEDGE 24
`define SY_CTL_W 25
`define SY_WD 25
`define SY_TD 34
`define SY_RD 43
`define SY_W 52
`endif

// >>> tape_xport_pkg.sv
// Types for the tape transport motion and write control block
`include "tape_xport_map.svh"
package tape_xport_pkg;
  typedef enum logic [1:0] {MOT_STOP, MOT_AHEAD, MOT_BACK, MOT_SPOOL} motion_e;
  typedef struct packed {
    logic [`SY_W-1:0] sync1;
    logic [`SY_W-1:0] sync2;
    logic [`SY_CTL_W-1:0] prev;
    motion_e motion;
    logic off_run;
    logic [31:0] ramp_cnt;
    logic [31:0] accel_cnt;
    logic at_speed;
    logic hs_ramp;
    logic write_en;
    logic lrc_armed;
    logic [8:0] head;
    logic [15:0] wclk_cnt;
    logic wclk;
    logic wclk_o;
    logic [7:0] skew_cnt;
    logic skew_busy;
    logic rstrobe;
    logic [8:0] rd_latch;
    logic [8:0] readback;
    logic preset_sel;
    logic [8:0] preset;
    logic [15:0] nrzi_div;
    logic [15:0] pe_div;
    logic [7:0] skew_dly;
    logic [31:0] rdata;
    logic cap_ahead;
    logic cap_back;
    logic [5:0] reel;
  } state_s;
endpackage
